// ### design/wrps_top.sv
`timescale 1ns/1ps
module wrps_top
  import wrps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic mainAnalogOk,
  input wire logic mainSupplyOk,
  input wire logic coreSupplyOk,
  input wire logic coreAboveLow,
  input wire logic core_supply_trim_fuse,
  input wire logic secondTick,
  input wire logic sleepRequest,
  input wire logic display_only_request,
  input wire logic general_pin_4,
  input wire logic general_pin_55,
  input wire logic pin4WakeEnable,
  input wire logic pin55WakeEnable,
  input wire logic push_button_input,
  input wire logic serialRxWake,
  input wire logic temperatureWake,
  input wire logic resetCauseValid,
  input wire logic [5:0] resetCauseCode,
  output logic referencePinEnable,
  output logic internalReferenceOff,
  output logic flashWriteBlock,
  output logic pllFastClear,
  output logic watchdogRestartPulse,
  output logic wakeEvent,
  output logic irq
);

  wrps_tmr_if tmrBus ();

  // Synchronisers for levels arriving from outside the clock domain
  logic [3:0] supS1_q;
  logic [3:0] supS2_q;
  logic fuseS1_q;
  logic fuseS2_q;
  logic [1:0] pinS1_q;
  logic [1:0] pinS2_q;
  logic [1:0] pinPrev_q;

  // Software visible state
  logic refOut_q;
  logic refDis_q;
  logic [7:0] wakeDur_q;
  logic [5:0] rstCause_q;
  logic [WAKE_SRC_N-1:0] wakeFlag_q;
  logic [WAKE_SRC_N-1:0] wakeFlag_d;
  logic [2:0] supply_q;
  logic [2:0] supply_d;
  logic [IRQ_N-1:0] irqStat_q;
  logic [IRQ_N-1:0] irqStat_d;
  logic [IRQ_N-1:0] irqMask_q;
  logic [7:0] rdData_q;
  logic wdPulse_q;
  logic flashBlock_q;
  logic pllClr_q;

  // Decoded strobes
  logic hitSupply;
  logic hitRef;
  logic hitDur;
  logic hitCause;
  logic hitFlags;
  logic hitArm;
  logic hitWdog;
  logic hitIrqStat;
  logic hitIrqMask;
  logic wrRef;
  logic wrDur;
  logic wrArm;
  logic wrWdog;
  logic wrIrqStat;
  logic wrIrqMask;
  logic [7:0] rdMux;

  // Wake sources
  logic [1:0] pinRise;
  logic [WAKE_SRC_N-1:0] wakeHit;
  logic [WAKE_SRC_N-1:0] wakeEnable;
  logic anyWake;
  logic [IRQ_N-1:0] irqEvent;
  logic [7:0] causeByte;
  logic [7:0] flagByte;

  // Two-stage capture; only stage two, and the pin copy taken from it for edge detect, feed any logic
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      supS1_q <= 4'h0;
      supS2_q <= 4'h0;
      fuseS1_q <= 1'b0;
      fuseS2_q <= 1'b0;
      pinS1_q <= 2'h0;
      pinS2_q <= 2'h0;
      pinPrev_q <= 2'h0;
    end
    else
    begin
      supS1_q <= {mainAnalogOk, mainSupplyOk, coreSupplyOk, coreAboveLow};
      supS2_q <= supS1_q;
      fuseS1_q <= core_supply_trim_fuse;
      fuseS2_q <= fuseS1_q;
      pinS1_q <= {general_pin_4, general_pin_55};
      pinS2_q <= pinS1_q;
      pinPrev_q <= pinS2_q;
    end
  end

  // Supply classification, main supply checked first
  assign supply_d =
    (supS2_q[3] && supS2_q[2]) ? SUP_MAIN_OK :
    supS2_q[2] ? SUP_MAIN_LOW :
    (supS2_q[1] && supS2_q[0]) ? SUP_BAT_OK :
    supS2_q[0] ? SUP_BAT_MID :
    SUP_BAT_FAIL;

  // Status and its consequences registered together so they agree
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      supply_q <= SUP_BAT_FAIL;
      flashBlock_q <= 1'b0; // Agrees with reset code 101
      pllClr_q <= 1'b0;
    end
    else
    begin
      supply_q <= supply_d;
      flashBlock_q <= (supply_d == SUP_BAT_MID);
      pllClr_q <= (supply_d == SUP_BAT_MID) && fuseS2_q;
    end
  end

  // Address decode
  assign hitSupply = (regAddr == OFF_SUPPLY);
  assign hitRef = (regAddr == OFF_REF);
  assign hitDur = (regAddr == OFF_WAKE_DUR);
  assign hitCause = (regAddr == OFF_RST_CAUSE);
  assign hitFlags = (regAddr == OFF_WAKE_FLAGS);
  assign hitArm = (regAddr == OFF_WAKE_ARM);
  assign hitWdog = (regAddr == OFF_WDOG);
  assign hitIrqStat = (regAddr == OFF_IRQ_STAT);
  assign hitIrqMask = (regAddr == OFF_IRQ_MASK);
  assign wrRef = regWrEn && hitRef;
  assign wrDur = regWrEn && hitDur;
  assign wrArm = regWrEn && hitArm;
  assign wrWdog = regWrEn && hitWdog;
  assign wrIrqStat = regWrEn && hitIrqStat;
  assign wrIrqMask = regWrEn && hitIrqMask;

  // Writable control registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refOut_q <= 1'b0;
      refDis_q <= 1'b0;
      wakeDur_q <= WAKE_DUR_RESET;
      irqMask_q <= IRQ_MASK_RESET;
    end
    else
    begin
      if (wrRef)
      begin
        refOut_q <= regWrData[BIT_REF_OUT];
        refDis_q <= regWrData[BIT_REF_DIS];
      end
      if (wrDur)
        wakeDur_q <= regWrData;
      if (wrIrqMask)
        irqMask_q <= regWrData[IRQ_N-1:0];
    end
  end

  // Disable overrides the pin path, reference cannot leave while off
  assign referencePinEnable = refOut_q && !refDis_q;
  assign internalReferenceOff = refDis_q;
  assign flashWriteBlock = flashBlock_q;
  assign pllFastClear = pllClr_q;

  // Watchdog restart is a pulse; nothing is stored, reads give zero
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      wdPulse_q <= 1'b0;
    else
      wdPulse_q <= wrWdog && regWrData[BIT_WDOG_RESTART];
  end
  assign watchdogRestartPulse = wdPulse_q;

  // Wake timer control; arm write of zero drops a pending arm
  assign tmrBus.load = wrArm && regWrData[BIT_WAKE_ARM];
  assign tmrBus.disarm = wrArm && !regWrData[BIT_WAKE_ARM];
  assign tmrBus.duration = wakeDur_q;
  assign tmrBus.run = sleepRequest || display_only_request;
  assign tmrBus.tick = secondTick;
  assign wakeEvent = tmrBus.expire;

  wrps_wake_timer u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .t(tmrBus)
  );

  // Wake sources; pins use rising edges detected after the synchroniser, with no debounce
  assign pinRise = pinS2_q & ~pinPrev_q;
  assign wakeHit[WS_PIN55] = pinRise[0] && pin55WakeEnable;
  assign wakeHit[WS_PIN4] = pinRise[1] && pin4WakeEnable;
  assign wakeHit[WS_BUTTON] = push_button_input;
  assign wakeHit[WS_RX] = serialRxWake;
  assign wakeHit[WS_TEMP] = temperatureWake;
  assign wakeEnable = {3'h7, pin4WakeEnable, pin55WakeEnable};
  assign anyWake = |wakeHit;

  // A new wake replaces the whole record so only the latest cause shows
  genvar gi;
  generate
    for (gi = 0; gi < WAKE_SRC_N; gi++)
    begin : g_flag
      assign wakeFlag_d[gi] = wakeEnable[gi] &&
        (anyWake ? wakeHit[gi] : wakeFlag_q[gi]);
    end
  endgenerate

  // Wake and reset cause records
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wakeFlag_q <= '0;
      rstCause_q <= RST_CAUSE_RESET;
    end
    else
    begin
      wakeFlag_q <= wakeFlag_d;
      if (resetCauseValid)
        rstCause_q <= resetCauseCode;
    end
  end

  // Interrupt events; a new event beats a write-one clear
  assign irqEvent[IRQ_TIMER] = tmrBus.expire;
  assign irqEvent[IRQ_WAKE] = anyWake;
  assign irqEvent[IRQ_SUPPLY] = (supply_d != supply_q);
  assign irqStat_d = irqEvent |
    (irqStat_q & ~(wrIrqStat ? regWrData[IRQ_N-1:0] : {IRQ_N{1'b0}}));

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      irqStat_q <= '0;
    else
      irqStat_q <= irqStat_d;
  end
  assign irq = |(irqStat_q & irqMask_q);

  // Read assembly; unmapped addresses and write-only bits read zero
  assign causeByte = {rstCause_q, 2'h0};
  assign flagByte = {1'b0, wakeFlag_q[WS_TEMP], 1'b0,
    wakeFlag_q[WS_RX], wakeFlag_q[WS_BUTTON], wakeFlag_q[WS_PIN4],
    1'b0, wakeFlag_q[WS_PIN55]};
  assign rdMux =
    hitSupply ? {5'h00, supply_q} :
    hitRef ? {refOut_q, refDis_q, 6'h00} :
    hitDur ? wakeDur_q :
    hitCause ? causeByte :
    hitFlags ? flagByte :
    hitArm ? {2'h0, tmrBus.armed, 5'h00} :
    hitIrqStat ? {5'h00, irqStat_q} :
    hitIrqMask ? {5'h00, irqMask_q} :
    8'h00;

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdData_q <= 8'h00;
    else if (regRdEn)
      rdData_q <= rdMux;
    else
      rdData_q <= 8'h00;
  end
  assign regRdData = rdData_q;

  sequence wdWrite_s;
    regWrEn && hitWdog && regWrData[BIT_WDOG_RESTART];
  endsequence

  sequence wdPulse_s;
    wdPulse_q ##1 !wdPulse_q;
  endsequence

  wd_restart_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wdWrite_s ##1 !(regWrEn && hitWdog) |-> wdPulse_s)
    else $error("watchdog restart pulse wrong");

  wd_readzero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    regRdEn && hitWdog |=> regRdData == 8'h00)
    else $error("watchdog register read not zero");

  ref_pin_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    referencePinEnable |-> refOut_q && !internalReferenceOff)
    else $error("reference routed while disabled");

  ref_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wrRef |=> internalReferenceOff == $past(regWrData[BIT_REF_DIS]))
    else $error("reference disable not applied");

  flash_block_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    flashWriteBlock == (supply_q == SUP_BAT_MID))
    else $error("flash block disagrees with supply");

  pll_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pllFastClear |-> supply_q == SUP_BAT_MID && $past(fuseS2_q))
    else $error("pll clear without cause");

  supply_fail_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(supS2_q[2:0]) == 3'h0 |-> supply_q == SUP_BAT_FAIL)
    else $error("low core supply not reported");

  pin4_held_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !$past(pin4WakeEnable) |-> !wakeFlag_q[WS_PIN4])
    else $error("pin 4 flag set while not enabled");

  pin4_rise_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pin4WakeEnable && pinRise[1] |=> wakeFlag_q[WS_PIN4])
    else $error("pin 4 rise not recorded");

  pin55_rise_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pin55WakeEnable && pinRise[0] |=> wakeFlag_q[WS_PIN55])
    else $error("pin 55 rise not recorded");

  flag_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !anyWake && wakeEnable[WS_RX] |=> $stable(wakeFlag_q[WS_RX]))
    else $error("wake flag changed without event");

  cause_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    resetCauseValid |=> rstCause_q == $past(resetCauseCode))
    else $error("reset cause not recorded");

  timer_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tmrBus.expire |=> irqStat_q[IRQ_TIMER])
    else $error("timer expiry lost");

endmodule : wrps_top

// ### design/wrps_pkg.sv
package wrps_pkg;

  // Register byte addresses on the plain register port
  localparam logic [15:0] OFF_SUPPLY = 16'h00F9;
  localparam logic [15:0] OFF_REF = 16'h2704;
  localparam logic [15:0] OFF_WAKE_DUR = 16'h2880;
  localparam logic [15:0] OFF_RST_CAUSE = 16'h28B0;
  localparam logic [15:0] OFF_WAKE_FLAGS = 16'h28B1;
  localparam logic [15:0] OFF_WAKE_ARM = 16'h28B2;
  localparam logic [15:0] OFF_WDOG = 16'h28B4;
  localparam logic [15:0] OFF_IRQ_STAT = 16'h28C0;
  localparam logic [15:0] OFF_IRQ_MASK = 16'h28C1;

  // Field positions
  localparam int unsigned BIT_REF_OUT = 7;
  localparam int unsigned BIT_REF_DIS = 6;
  localparam int unsigned BIT_WAKE_ARM = 5;
  localparam int unsigned BIT_WDOG_RESTART = 7;
  localparam int unsigned BIT_CAUSE_LSB = 2;
  localparam int unsigned BIT_WF_PIN55 = 0;
  localparam int unsigned BIT_WF_PIN4 = 2;
  localparam int unsigned BIT_WF_BUTTON = 3;
  localparam int unsigned BIT_WAKE_FLAG_SERIAL_RX = 4;
  localparam int unsigned BIT_WAKE_FLAG_TEMPERATURE = 6;

  // Wake source index inside the flag vector
  localparam int unsigned WAKE_SRC_N = 5;
  localparam int unsigned WS_PIN55 = 0;
  localparam int unsigned WS_PIN4 = 1;
  localparam int unsigned WS_BUTTON = 2;
  localparam int unsigned WS_RX = 3;
  localparam int unsigned WS_TEMP = 4;

  // Interrupt status bits
  localparam int unsigned IRQ_N = 3;
  localparam int unsigned IRQ_TIMER = 0;
  localparam int unsigned IRQ_WAKE = 1;
  localparam int unsigned IRQ_SUPPLY = 2;

  // Supply status codes
  localparam logic [2:0] SUP_MAIN_OK = 3'h0;
  localparam logic [2:0] SUP_MAIN_LOW = 3'h1;
  localparam logic [2:0] SUP_BAT_OK = 3'h2;
  localparam logic [2:0] SUP_BAT_MID = 3'h3;
  localparam logic [2:0] SUP_BAT_FAIL = 3'h5;

  // Reset values; cause bits ordered cold,pin,soft,wdog,ext,badbat
  localparam logic [5:0] RST_CAUSE_RESET = 6'h10;
  localparam logic [7:0] WAKE_DUR_RESET = 8'h00;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

endpackage : wrps_pkg

// ### design/wrps_tmr_if.sv
`timescale 1ns/1ps
interface wrps_tmr_if;
  logic load;
  logic disarm;
  logic [7:0] duration;
  logic run;
  logic tick;
  logic armed;
  logic expire;

  modport ctl (output load, output disarm, output duration, output run,
    output tick, input armed, input expire);
  modport tmr (input load, input disarm, input duration, input run,
    input tick, output armed, output expire);
endinterface : wrps_tmr_if

// ### design/wrps_wake_timer.sv
`timescale 1ns/1ps
module wrps_wake_timer
  import wrps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  wrps_tmr_if.tmr t
);

  logic armed_q;
  logic [7:0] count_q;
  logic expire_q;
  logic step;
  logic atEnd;

  // Count only on a seconds tick while armed and a sleep mode is asked for
  assign step = armed_q && t.run && t.tick;
  assign atEnd = (count_q == 8'h00);

  // Loading N gives N+1 ticks before expiry, so zero still means one second
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      armed_q <= 1'b0;
      count_q <= 8'h00;
    end
    else if (t.load)
    begin
      armed_q <= 1'b1;
      count_q <= t.duration;
    end
    else if (t.disarm)
    begin
      armed_q <= 1'b0;
    end
    else if (step)
    begin
      if (atEnd)
        armed_q <= 1'b0;
      else
        count_q <= count_q - 8'h01;
    end
  end

  // One-cycle expiry pulse
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      expire_q <= 1'b0;
    else
      expire_q <= step && atEnd && !t.load && !t.disarm;
  end

  assign t.armed = armed_q;
  assign t.expire = expire_q;

  expire_cause_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(expire_q) |-> $past(armed_q) && !armed_q)
    else $error("expiry without an armed timer");

  load_count_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    t.load |=> armed_q && count_q == $past(t.duration))
    else $error("arm did not load the duration");

endmodule : wrps_wake_timer

// ### bench/tb.sv
`timescale 1ns/1ps
module tb;
  import wrps_pkg::*;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0] regWrData = 8'h00;
  logic regWrEn = 1'h0;
  logic regRdEn = 1'h0;
  logic [7:0] regRdData;
  logic [3:0] supIn = 4'hF;
  logic core_supply_trim_fuse = 1'h1;
  logic secondTick = 1'h0;
  logic sleepRequest = 1'h0;
  logic display_only_request = 1'h0;
  logic general_pin_4 = 1'h0;
  logic general_pin_55 = 1'h0;
  logic pin4WakeEnable = 1'h0;
  logic pin55WakeEnable = 1'h0;
  logic [2:0] wakeP = 3'h0;
  logic resetCauseValid = 1'h0;
  logic [5:0] resetCauseCode = 6'h00;
  logic referencePinEnable, internalReferenceOff, flashWriteBlock;
  logic pllFastClear, watchdogRestartPulse, wakeEvent, irq;
  int n_mismatch = 0;
  int n_tests = 0;
  logic [3:0] supTab [5] = '{4'hF, 4'h4, 4'h3, 4'h1, 4'h0};
  logic [2:0] supExp [5] = '{SUP_MAIN_OK, SUP_MAIN_LOW, SUP_BAT_OK,
    SUP_BAT_MID, SUP_BAT_FAIL};
  logic [7:0] flagExp [3] = '{8'h08, 8'h10, 8'h40};

  wrps_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .mainAnalogOk(supIn[3]),
    .mainSupplyOk(supIn[2]), .coreSupplyOk(supIn[1]),
    .coreAboveLow(supIn[0]), .core_supply_trim_fuse(core_supply_trim_fuse),
    .secondTick(secondTick), .sleepRequest(sleepRequest),
    .display_only_request(display_only_request),
    .general_pin_4(general_pin_4), .general_pin_55(general_pin_55),
    .pin4WakeEnable(pin4WakeEnable), .pin55WakeEnable(pin55WakeEnable),
    .push_button_input(wakeP[0]), .serialRxWake(wakeP[1]),
    .temperatureWake(wakeP[2]), .resetCauseValid(resetCauseValid),
    .resetCauseCode(resetCauseCode),
    .referencePinEnable(referencePinEnable),
    .internalReferenceOff(internalReferenceOff),
    .flashWriteBlock(flashWriteBlock), .pllFastClear(pllFastClear),
    .watchdogRestartPulse(watchdogRestartPulse), .wakeEvent(wakeEvent),
    .irq(irq));

  // Free-running 100 MHz clock
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  // One-cycle write; a gap cycle keeps strobe edges apart
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'h1;
    @(posedge sys_clk);
    regWrEn <= 1'h0;
  endtask : wr

  // Data is only valid in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRdEn <= 1'h1;
    @(posedge sys_clk);
    regRdEn <= 1'h0;
    #1 chk(regRdData, exp);
  endtask : rd

  task automatic tick(input logic exp);
    @(posedge sys_clk);
    secondTick <= 1'h1;
    @(posedge sys_clk);
    secondTick <= 1'h0;
    #1 chk({7'h00, wakeEvent}, {7'h00, exp});
  endtask : tick

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  // Hang guard
  initial
  begin
    #500000;
    n_mismatch++;
    $display("ERROR %0t: run did not complete", $time);
    results();
  end

  // Main sequence; every input change lands on a rising edge
  initial
  begin
    cyc(3);
    rst_n <= 1'h1;
    rd(OFF_RST_CAUSE, 8'h40);
    @(posedge sys_clk);
    #1 chk(regRdData, 8'h00);
    wr(OFF_RST_CAUSE, 8'hFF);
    rd(OFF_RST_CAUSE, 8'h40);
    rd(OFF_REF, 8'h00);
    rd(OFF_WAKE_DUR, 8'h00);
    rd(OFF_WAKE_FLAGS, 8'h00);
    rd(OFF_WAKE_ARM, 8'h00);
    rd(16'h1234, 8'h00);
    done("reset");
    wr(OFF_REF, 8'h80);
    #1 chk({6'h00, referencePinEnable, internalReferenceOff}, 8'h02);
    wr(OFF_REF, 8'hC0);
    #1 chk({6'h00, referencePinEnable, internalReferenceOff},
      8'h01);
    rd(OFF_REF, 8'hC0);
    wr(OFF_REF, 8'h00);
    #1 chk({6'h00, referencePinEnable, internalReferenceOff}, 8'h00);
    done("reference");
    wr(OFF_WDOG, 8'h80);
    #1 chk({7'h00, watchdogRestartPulse}, 8'h01);
    @(posedge sys_clk);
    #1 chk({7'h00, watchdogRestartPulse}, 8'h00);
    wr(OFF_WDOG, 8'h00);
    #1 chk({7'h00, watchdogRestartPulse}, 8'h00);
    rd(OFF_WDOG, 8'h00);
    done("watchdog");
    // Every supply code, fuse blown
    for (int i = 0; i < 5; i++)
    begin
      @(posedge sys_clk);
      supIn <= supTab[i];
      cyc(4);
      rd(OFF_SUPPLY, {5'h00, supExp[i]});
      chk({7'h00, flashWriteBlock}, {7'h00, supExp[i] == 3'h3});
      chk({7'h00, pllFastClear}, {7'h00, supExp[i] == 3'h3});
    end
    @(posedge sys_clk);
    supIn <= 4'h1;
    core_supply_trim_fuse <= 1'h0;
    cyc(4);
    #1 chk({7'h00, pllFastClear}, 8'h00);
    chk({7'h00, flashWriteBlock}, 8'h01);
    @(posedge sys_clk);
    supIn <= 4'hF;
    cyc(4);
    // Supply changes leave only the supply event pending
    rd(OFF_IRQ_STAT, 8'h04);
    wr(OFF_IRQ_STAT, 8'h07);
    rd(OFF_IRQ_STAT, 8'h00);
    done("supply");
    // Timer ignores ticks until a sleep mode is asked
    wr(OFF_IRQ_MASK, 8'h01);
    wr(OFF_WAKE_DUR, 8'h02);
    wr(OFF_WAKE_ARM, 8'h20);
    rd(OFF_WAKE_ARM, 8'h20);
    rd(OFF_WAKE_DUR, 8'h02);
    repeat (3) tick(1'h0);
    @(posedge sys_clk);
    sleepRequest <= 1'h1;
    tick(1'h0);
    tick(1'h0);
    tick(1'h1);
    @(posedge sys_clk);
    #1 chk({7'h00, wakeEvent}, 8'h00);
    chk({7'h00, irq}, 8'h01);
    rd(OFF_WAKE_ARM, 8'h00);
    rd(OFF_IRQ_STAT, 8'h01);
    wr(OFF_IRQ_STAT, 8'h01);
    #1 chk({7'h00, irq}, 8'h00);
    @(posedge sys_clk);
    sleepRequest <= 1'h0;
    // Shortest interval, display mode, interrupt masked
    wr(OFF_IRQ_MASK, 8'h00);
    wr(OFF_WAKE_DUR, 8'h00);
    wr(OFF_WAKE_ARM, 8'h20);
    display_only_request <= 1'h1;
    tick(1'h1);
    cyc(2);
    #1 chk({7'h00, irq}, 8'h00);
    rd(OFF_IRQ_STAT, 8'h01);
    wr(OFF_IRQ_MASK, 8'h01);
    #1 chk({7'h00, irq}, 8'h01);
    wr(OFF_IRQ_STAT, 8'h01);
    display_only_request <= 1'h0;
    // Writing zero to the arm bit drops a pending arm
    wr(OFF_WAKE_ARM, 8'h20);
    wr(OFF_WAKE_ARM, 8'h00);
    rd(OFF_WAKE_ARM, 8'h00);
    done("wake timer");
    // Pin flag stays clear while pin is not a wake source
    @(posedge sys_clk);
    general_pin_4 <= 1'h1;
    cyc(5);
    rd(OFF_WAKE_FLAGS, 8'h00);
    @(posedge sys_clk);
    general_pin_4 <= 1'h0;
    cyc(5);
    pin4WakeEnable <= 1'h1;
    @(posedge sys_clk);
    general_pin_4 <= 1'h1;
    cyc(5);
    rd(OFF_WAKE_FLAGS, 8'h04);
    @(posedge sys_clk);
    pin55WakeEnable <= 1'h1;
    @(posedge sys_clk);
    general_pin_55 <= 1'h1;
    cyc(5);
    rd(OFF_WAKE_FLAGS, 8'h01);
    @(posedge sys_clk);
    pin55WakeEnable <= 1'h0;
    cyc(2);
    rd(OFF_WAKE_FLAGS, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge sys_clk);
      wakeP <= 3'h1 << i;
      @(posedge sys_clk);
      wakeP <= 3'h0;
      cyc(2);
      rd(OFF_WAKE_FLAGS, flagExp[i]);
    end
    // Every wake above also raised the wake interrupt event
    rd(OFF_IRQ_STAT, 8'h02);
    done("wake flags");
    // Each reset source replaces the previous record
    for (int i = 0; i < 6; i++)
    begin
      @(posedge sys_clk);
      resetCauseCode <= 6'h20 >> i;
      resetCauseValid <= 1'h1;
      @(posedge sys_clk);
      resetCauseValid <= 1'h0;
      rd(OFF_RST_CAUSE, {6'h20 >> i, 2'h0});
    end
    done("reset cause");
    results();
  end
endmodule : tb
